// ===== logic/irqsm_top.sv
// interrupt status, mask and raw flag registers behind an ahb-lite slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module irqsm_top
  import irqsm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] alarm_chan_in,
  input wire logic host_interface_error_in,
  input wire logic boot_complete_in,
  input wire logic processor_clock_starved_in,
  input wire logic async_domain_starved_in,
  input wire logic system_domain_starved_in,
  input wire logic freq_loop_a_locked_in,
  input wire logic freq_loop_b_locked_in,
  input wire logic freq_loop_a_ref_missing_in,
  input wire logic freq_loop_b_ref_missing_in,
  output logic irq
);

  typedef enum logic [1:0] {
    IRQSM_IDLE = 2'b00,
    IRQSM_RD_WAIT = 2'b01,
    IRQSM_WR_DATA = 2'b10
  } irqsm_phase_type;

  function automatic logic [15:0] irqsm_idx(input logic [31:0] a);
    irqsm_idx = a[17:2];
  endfunction : irqsm_idx

  function automatic logic irqsm_mapped(input logic [31:0] a);
    irqsm_mapped = (a[31:18] == ADDR_HI_ZERO) && (a[1:0] == 2'h0);
  endfunction : irqsm_mapped

  logic [LIVE_W-1:0] live_raw;
  logic [LIVE_W-1:0] live_s;
  logic [LIVE_W-1:0] live_prev_q;
  logic [LIVE_W-1:0] live_rise;
  logic [ALARM_W-1:0] alarm_event_q;
  logic [ALARM_W-1:0] alarm_mask_q;
  logic [15:0] raw_if_q;
  logic [15:0] raw_clk_q;
  logic [15:0] raw_if_d;
  logic [15:0] raw_clk_d;
  logic [15:0] chg_event_q;
  logic [15:0] chg_mask_q;
  logic [15:0] chg_rise;
  irqsm_phase_type phase_q;
  logic [15:0] idx_q;
  logic ok_q;
  logic accept;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_word;
  logic [ALARM_W-1:0] alarm_clr;
  logic [15:0] chg_clr;

  assign live_raw = {freq_loop_b_ref_missing_in, freq_loop_a_ref_missing_in,
                     freq_loop_b_locked_in, freq_loop_a_locked_in,
                     system_domain_starved_in, async_domain_starved_in,
                     processor_clock_starved_in, boot_complete_in,
                     host_interface_error_in, alarm_chan_in};

  // every live condition may come from another clock, so all are synchronised
  irqsm_sync #(
    .W(LIVE_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(live_raw),
    .sync_out(live_s)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      live_prev_q <= '0;
    end else begin
      live_prev_q <= live_s;
    end
  end

  assign live_rise = live_s & ~live_prev_q;

  // raw flag words assembled from synchronised conditions
  always_comb begin
    raw_if_d = 16'h0000;
    raw_if_d[BIT_IF_ERR] = live_s[LV_IF_ERR];
    raw_if_d[BIT_BOOT] = live_s[LV_BOOT];
    raw_clk_d = 16'h0000;
    raw_clk_d[BIT_PROC_STARVE] = live_s[LV_PROC];
    raw_clk_d[BIT_ASYNC_STARVE] = live_s[LV_ASYNC];
    raw_clk_d[BIT_SYS_STARVE] = live_s[LV_SYS];
    raw_clk_d[BIT_LB_LOCK] = live_s[LV_LB_LOCK];
    raw_clk_d[BIT_LB_REF] = live_s[LV_LB_REF];
    raw_clk_d[BIT_LA_LOCK] = live_s[LV_LA_LOCK];
    raw_clk_d[BIT_LA_REF] = live_s[LV_LA_REF];
  end

  // raw words have no write path at all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_if_q <= 16'h0000;
      raw_clk_q <= 16'h0000;
    end else begin
      raw_if_q <= raw_if_d;
      raw_clk_q <= raw_clk_d;
    end
  end

  // bus slave: writes take no wait state, reads take one so hrdata is a flop
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wr_en = (phase_q == IRQSM_WR_DATA) && ok_q;
  assign rd_en = (phase_q == IRQSM_RD_WAIT) && ok_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= IRQSM_IDLE;
      idx_q <= 16'h0000;
      ok_q <= 1'b0;
    end else begin
      case (phase_q)
        IRQSM_RD_WAIT: begin
          phase_q <= IRQSM_IDLE;
        end
        default: begin
          if (accept) begin
            phase_q <= hwrite ? IRQSM_WR_DATA : IRQSM_RD_WAIT;
            idx_q <= irqsm_idx(haddr);
            ok_q <= irqsm_mapped(haddr);
          end else begin
            phase_q <= IRQSM_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(phase_q != IRQSM_RD_WAIT && accept && !hwrite);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // read mux; other mask words of the bank and unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (idx_q)
      IDX_ALARM: rd_word = {28'h000_0000, alarm_event_q};
      IDX_ALARM_MASK: rd_word = {28'h000_0000, alarm_mask_q};
      IDX_RAW_IF: rd_word = {16'h0000, raw_if_q};
      IDX_RAW_CLK: rd_word = {16'h0000, raw_clk_q};
      IDX_CHG_EVT: rd_word = {16'h0000, chg_event_q};
      IDX_CHG_MASK: rd_word = {16'h0000, chg_mask_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (phase_q == IRQSM_RD_WAIT) begin
      // an unmapped read returns zero rather than the last word read
      hrdata <= ok_q ? rd_word : 32'h0000_0000;
    end
  end

  // alarm events: rising edge sets, writing one clears, set beats clear
  assign alarm_clr = (wr_en && idx_q == IDX_ALARM) ? hwdata[ALARM_W-1:0] : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_event_q <= 4'h0;
    end else begin
      alarm_event_q <= (alarm_event_q & ~alarm_clr) | live_rise[ALARM_W-1:0];
    end
  end

  // masks reset to blocked so nothing fires before software sets up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_mask_q <= ALARM_MASK_RST;
    end else if (wr_en && idx_q == IDX_ALARM_MASK) begin
      alarm_mask_q <= hwdata[ALARM_W-1:0];
    end
  end

  // change events on raw flags: sticky, cleared by reading the word
  always_comb begin
    chg_rise = 16'h0000;
    chg_rise[BIT_PROC_STARVE] = live_rise[LV_PROC];
    chg_rise[BIT_ASYNC_STARVE] = live_rise[LV_ASYNC];
    chg_rise[BIT_SYS_STARVE] = live_rise[LV_SYS];
    chg_rise[BIT_LB_LOCK] = live_rise[LV_LB_LOCK];
    chg_rise[BIT_LA_LOCK] = live_rise[LV_LA_LOCK];
    chg_rise[BIT_BOOT] = live_rise[LV_BOOT];
    chg_rise[BIT_LB_REF] = live_rise[LV_LB_REF];
    chg_rise[BIT_LA_REF] = live_rise[LV_LA_REF];
    chg_rise[BIT_CHG_IF_ERR] = live_rise[LV_IF_ERR];
  end

  assign chg_clr = (rd_en && idx_q == IDX_CHG_EVT) ? CHG_VALID : 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chg_event_q <= 16'h0000;
    end else begin
      chg_event_q <= (chg_event_q & ~chg_clr) | chg_rise;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chg_mask_q <= CHG_MASK_RST;
    end else if (wr_en && idx_q == IDX_CHG_MASK) begin
      chg_mask_q <= hwdata[15:0] & CHG_VALID;
    end
  end

  // interrupt is one flop behind the status bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(alarm_event_q & ~alarm_mask_q)) | (|(chg_event_q & ~chg_mask_q));
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_addr;
    hreadyout && accept && !hwrite;
  endsequence

  sequence s_rd_done;
    !hreadyout ##1 hreadyout;
  endsequence

  sequence s_alarm_wr(int b, logic v);
    wr_en && idx_q == IDX_ALARM && hwdata[b] == v;
  endsequence

  chk_read_one_wait: assert property (
    s_rd_addr |=> s_rd_done)
    else $error("read did not complete after exactly one wait state");

  chk_alarm_set_edge: assert property (
    live_s[0] && !live_prev_q[0] |=> alarm_event_q[0])
    else $error("alarm channel 1 edge did not set its event bit");

  chk_alarm_zero_keeps: assert property (
    (alarm_event_q[3] and s_alarm_wr(3, 1'b0)) |=> alarm_event_q[3])
    else $error("writing zero cleared an alarm event bit");

  chk_alarm_one_clears: assert property (
    (alarm_event_q[2] and s_alarm_wr(2, 1'b1) and !live_rise[2]) |=> !alarm_event_q[2])
    else $error("writing one did not clear an alarm event bit");

  chk_alarm_no_spont: assert property (
    !alarm_event_q[1] && !live_rise[1] |=> !alarm_event_q[1])
    else $error("alarm event bit set without a rising edge");

  chk_mask_write_store: assert property (
    wr_en && idx_q == IDX_ALARM_MASK |=> alarm_mask_q == $past(hwdata[3:0]))
    else $error("alarm mask write not stored");

  chk_irq_unmasked: assert property (
    alarm_event_q[0] && !alarm_mask_q[0] |=> irq)
    else $error("unmasked alarm event did not raise interrupt");

  chk_irq_all_masked: assert property (
    (alarm_mask_q == 4'hF) && ((chg_mask_q & CHG_VALID) == CHG_VALID) |=> !irq)
    else $error("interrupt high with every source masked");

  chk_raw_boot_follow: assert property (
    live_s[LV_BOOT] [*2] |=> raw_if_q[BIT_BOOT])
    else $error("boot flag did not follow boot completion");

  chk_raw_iferr_follow: assert property (
    ##1 raw_if_q[BIT_IF_ERR] == $past(live_s[LV_IF_ERR]))
    else $error("interface error flag does not follow its condition");

  chk_raw_clk_follow: assert property (
    ##1 raw_clk_q[BIT_PROC_STARVE] == $past(live_s[LV_PROC]))
    else $error("clocking flags do not follow live conditions");

  chk_raw_clk_ro: assert property (
    wr_en && idx_q == IDX_RAW_CLK && !live_s[LV_SYS] |=> !raw_clk_q[BIT_SYS_STARVE])
    else $error("host write changed a raw clocking flag");

  chk_loops_follow: assert property (
    live_s[LV_LB_LOCK] && live_s[LV_LA_REF] |=> raw_clk_q[BIT_LB_LOCK] && raw_clk_q[BIT_LA_REF])
    else $error("loop lock or reference flag lost");

  chk_loop_a_lock: assert property (
    !live_s[LV_LA_LOCK] |=> !raw_clk_q[BIT_LA_LOCK])
    else $error("loop a lock flag set while unlocked");

  chk_starve_bits: assert property (
    live_s[LV_ASYNC] && !live_s[LV_SYS] |=> raw_clk_q[13] && !raw_clk_q[12])
    else $error("starvation flags at wrong positions");

  sequence s_chg_read;
    rd_en && idx_q == IDX_CHG_EVT;
  endsequence

  chk_chg_read_clear: assert property (
    (s_chg_read and !(|chg_rise)) |=> chg_event_q == 16'h0000)
    else $error("reading the change word did not empty it");

  chk_chg_set_wins: assert property (
    (|chg_rise) |=> (chg_event_q & $past(chg_rise)) == $past(chg_rise))
    else $error("change event lost against a clear");

  chk_alarm_set_wins: assert property (
    live_rise[3] |=> alarm_event_q[3])
    else $error("alarm channel 4 edge lost against a clear");

  chk_irq_falls: assert property (
    (alarm_event_q & ~alarm_mask_q) == 4'h0
      && (chg_event_q & ~chg_mask_q) == 16'h0000 |=> !irq)
    else $error("interrupt high with no unmasked event");

  chk_raw_if_ro: assert property (
    wr_en && idx_q == IDX_RAW_IF |=> raw_if_q[BIT_BOOT] == $past(live_s[LV_BOOT]))
    else $error("host write changed the boot flag");

  chk_raw_lb_ref: assert property (
    !live_s[LV_LB_REF] |=> !raw_clk_q[BIT_LB_REF])
    else $error("loop b reference flag set while reference present");

endmodule : irqsm_top

// ===== logic/irqsm_pkg.sv
// constants for the interrupt status, mask and raw flag block
//Contract
//- four alarm event bits 3..0, channels 4..1, set on rising edge, reset zero
//- an event bit clears only on writing one; writing zero keeps it
//- each event bit has a mask bit at the same position in the mask range
//- mask bit 0 lets the event reach the interrupt, 1 blocks it
//- host interface error is a raw flag at bit 12, reset zero
//- boot flag at bit 7 reads 0 while booting, 1 when finished
//- bit 14 raw error while processor clock is too slow
//- bit 13 raw error while async domain clock is too slow
//- bit 12 of clocking status raw error while system domain clock is too slow
//- loop b: lock at bit 9, reference missing at bit 6, reset zero
//- loop a: lock at bit 8, reference missing at bit 5, reset zero
package irqsm_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_ALARM = 16'h1823;
  localparam logic [15:0] IDX_MASK_FIRST = 16'h1840;
  localparam logic [15:0] IDX_MASK_LAST = 16'h1863;
  localparam logic [15:0] IDX_ALARM_MASK = 16'h1863;
  localparam logic [15:0] IDX_RAW_IF = 16'h1880;
  localparam logic [15:0] IDX_RAW_CLK = 16'h1881;
  localparam logic [15:0] IDX_CHG_EVT = 16'h1890;
  localparam logic [15:0] IDX_CHG_MASK = 16'h1891;
  localparam int ALARM_W = 4;
  localparam logic [3:0] ALARM_MASK_RST = 4'hF;
  localparam logic [15:0] CHG_MASK_RST = 16'hFFFF;
  localparam logic [15:0] CHG_VALID = 16'h73E1;
  // raw flag positions
  localparam int BIT_IF_ERR = 12;
  localparam int BIT_BOOT = 7;
  localparam int BIT_PROC_STARVE = 14;
  localparam int BIT_ASYNC_STARVE = 13;
  localparam int BIT_SYS_STARVE = 12;
  localparam int BIT_LB_LOCK = 9;
  localparam int BIT_LA_LOCK = 8;
  localparam int BIT_LB_REF = 6;
  localparam int BIT_LA_REF = 5;
  localparam int BIT_CHG_IF_ERR = 0;
  // synchronised live input vector layout
  localparam int LIVE_W = 13;
  localparam int LV_IF_ERR = 4;
  localparam int LV_BOOT = 5;
  localparam int LV_PROC = 6;
  localparam int LV_ASYNC = 7;
  localparam int LV_SYS = 8;
  localparam int LV_LA_LOCK = 9;
  localparam int LV_LB_LOCK = 10;
  localparam int LV_LA_REF = 11;
  localparam int LV_LB_REF = 12;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [13:0] ADDR_HI_ZERO = 14'h0000;
endpackage : irqsm_pkg

// ===== logic/irqsm_sync.sv
// two flip-flop synchroniser for the live condition inputs
`timescale 1ns/1ps
module irqsm_sync #(
  parameter int W = 13
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : irqsm_sync

// ===== dv/irqsm_host.sv
// host model: ahb-lite master that reads and clears the status and mask registers
`timescale 1ns/1ps
module irqsm_host
  import irqsm_pkg::*;
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic hung
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hung = 1'b0;
  end

  // one single word transfer; waits are bounded, a stuck slave raises hung
  task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 128);
    rd = hrdata;
    // released data must not keep looking valid
    hwdata <= ~wd;
    if (n >= 128) hung <= 1'b1;
  endtask : xfer

  // no control writes go out before the boot flag reads one or 32 reads pass
  task automatic wait_boot(output logic ok);
    logic [31:0] d;
    ok = 1'b0;
    for (int i = 0; i < 32 && !ok; i++) begin
      xfer({ADDR_HI_ZERO, IDX_RAW_IF, 2'b00}, 1'b0, 32'h0000_0000, d);
      ok = (d[BIT_BOOT] === 1'b1);
    end
  endtask : wait_boot
endmodule : irqsm_host

// ===== dv/irq_status_mask_raw_flags_test.sv
// self-checking bench for the interrupt status, mask and raw flag block
`timescale 1ns/1ps
module irq_status_mask_raw_flags_test
  import irqsm_pkg::*;
;
  localparam logic [31:0] Z = 32'h0000_0000;
  localparam int POS[8] = '{BIT_IF_ERR, BIT_PROC_STARVE, BIT_ASYNC_STARVE, BIT_SYS_STARVE,
    BIT_LA_LOCK, BIT_LB_LOCK, BIT_LA_REF, BIT_LB_REF};
  logic hclk;
  logic hresetn;
  logic hsel, hwrite, hreadyout, hresp, irq, hung, ok;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] alarm;
  logic [8:0] live;
  int fail_count;
  int n_checks;

  irqsm_top DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .alarm_chan_in(alarm),
    .host_interface_error_in(live[0]), .boot_complete_in(live[8]),
    .processor_clock_starved_in(live[1]), .async_domain_starved_in(live[2]),
    .system_domain_starved_in(live[3]), .freq_loop_a_locked_in(live[4]),
    .freq_loop_b_locked_in(live[5]), .freq_loop_a_ref_missing_in(live[6]),
    .freq_loop_b_ref_missing_in(live[7]), .irq(irq)
  );

  irqsm_host host (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung)
  );

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  function automatic logic [31:0] ad(input logic [15:0] idx);
    return {ADDR_HI_ZERO, idx, 2'b00};
  endfunction : ad

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : wt

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.xfer(a, 1'b0, Z, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] d;
    host.xfer(a, 1'b1, v, d);
  endtask : wr

  // reset state and refused places, all read before boot completes
  task automatic t_reset;
    chk({31'h0000_0000, irq}, Z);
    rd_chk(ad(IDX_ALARM), Z);
    rd_chk(ad(IDX_ALARM_MASK), {28'h000_0000, ALARM_MASK_RST});
    // unmapped read right after a non-zero word, so stale data would show
    rd_chk(32'h0004_608C, Z);
    rd_chk(ad(IDX_RAW_IF), Z);
    rd_chk(ad(IDX_RAW_CLK), Z);
    rd_chk(ad(IDX_MASK_FIRST), Z);
  endtask : t_reset

  // the input stays high after the clear, so only an edge may set the bit again
  task automatic t_alarm;
    wr(ad(IDX_ALARM_MASK), Z);
    for (int i = 0; i < ALARM_W; i++) begin
      @(posedge hclk);
      alarm[i] <= 1'b1;
      wt(4);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      rd_chk(ad(IDX_ALARM), 32'h0000_0001 << i);
      wr(ad(IDX_ALARM), Z);
      rd_chk(ad(IDX_ALARM), 32'h0000_0001 << i);
      wr(ad(IDX_ALARM_MASK), 32'h0000_0001 << i);
      wt(2);
      chk({31'h0000_0000, irq}, Z);
      wr(ad(IDX_ALARM_MASK), Z);
      wt(2);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      wr(ad(IDX_ALARM), 32'h0000_0001 << i);
      wt(2);
      chk({31'h0000_0000, irq}, Z);
      rd_chk(ad(IDX_ALARM), Z);
      @(posedge hclk);
      alarm[i] <= 1'b0;
    end
  endtask : t_alarm

  task automatic t_raw;
    logic [31:0] exp;
    logic [15:0] idx;
    for (int k = 0; k < 8; k++) begin
      idx = (k == 0) ? IDX_RAW_IF : IDX_RAW_CLK;
      exp = (32'h0000_0001 << POS[k]) | ((k == 0) ? 32'h0000_0080 : Z);
      @(posedge hclk);
      live[k] <= 1'b1;
      wt(4);
      rd_chk(ad(idx), exp);
      wr(ad(idx), 32'hFFFF_FFFF);
      chk({31'h0000_0000, hresp}, Z);
      rd_chk(ad(idx), exp);
      @(posedge hclk);
      live[k] <= 1'b0;
      wt(4);
      rd_chk(ad(idx), exp ^ (32'h0000_0001 << POS[k]));
    end
  endtask : t_raw

  // sticky change word: a read empties it, and the level output follows
  task automatic t_change;
    logic [31:0] d;
    host.xfer(ad(IDX_CHG_EVT), 1'b0, Z, d);
    wr(ad(IDX_CHG_MASK), 32'h0000_FEFF);
    @(posedge hclk);
    live[4] <= 1'b1;
    live[5] <= 1'b1;
    live[6] <= 1'b1;
    wt(6);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rd_chk(ad(IDX_RAW_CLK), 32'h0000_0320);
    rd_chk(ad(IDX_CHG_EVT), 32'h0000_0320);
    wt(2);
    chk({31'h0000_0000, irq}, Z);
    rd_chk(ad(IDX_CHG_EVT), Z);
  endtask : t_change

  initial begin
    for (int c = 0; c < 40000 && hung !== 1'b1; c++) @(posedge hclk);
    fail_count++;
    finish_test();
  end

  initial begin
    hresetn = 1'b0;
    alarm = 4'h0;
    live = 9'h000;
    fail_count = 0;
    n_checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    @(posedge hclk);
    live[8] <= 1'b1;
    host.wait_boot(ok);
    chk({31'h0000_0000, ok}, 32'h0000_0001);
    t_alarm();
    t_raw();
    t_change();
    finish_test();
  end
endmodule : irq_status_mask_raw_flags_test
